// File: csx_regs.svh
`ifndef CSX_REGS_SVH
`define CSX_REGS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define CSX_ADDR_W 12
`define CSX_CTRL_ADDR 12'h10A
`define CSX_STAT_ADDR 12'h1F0

// ****************************************************************
// Reset values and write mask
// ****************************************************************
`define CSX_CTRL_RESET 16'h0000
`define CSX_CTRL_WMASK 16'h7F55
`define CSX_RDATA_IDLE 16'h0000

// ****************************************************************
// Field positions of the control register
// ****************************************************************
`define CSX_BIT_EUP_EN 14
`define CSX_BIT_WIDE_SRAM 13
`define CSX_BIT_EMU_WS0 12
`define CSX_BIT_D_WS0 11
`define CSX_BIT_C_WS0 10
`define CSX_BIT_B_WS0 9
`define CSX_BIT_A_WS0 8
`define CSX_BIT_DRAM_EXT 6
`define CSX_BIT_D_UPS2 4
`define CSX_BIT_C_UPS2 2
`define CSX_BIT_B_UPS2 0

// ****************************************************************
// Decode constants
// ****************************************************************
`define CSX_WAIT_EXT_CODE 3'h7
`define CSX_UPS_TOP 3'h7
`define CSX_DCODE_8M 3'h0
`define CSX_DCODE_16M 3'h1
`define CSX_DRAM_8M 32'h0080_0000
`define CSX_DRAM_16M 32'h0100_0000

`endif

// File: csx_pkg.sv
`default_nettype none
`include "csx_regs.svh"

package csx_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic       rsv15;
      logic       extra_unprot_size_enable;
      logic       wide_sram_select;
      logic       emu_wait_low_bit;
      logic       group_d_wait_low_bit;
      logic       group_c_wait_low_bit;
      logic       group_b_wait_low_bit;
      logic       group_a_wait_low_bit;
      logic       rsv7;
      logic       dram_space_extend;
      logic       rsv5;
      logic       group_d_unprot_high_bit;
      logic       rsv3;
      logic       group_c_unprot_high_bit;
      logic       rsv1;
      logic       group_b_unprot_high_bit;
   } csx_ctrl_t;

   typedef struct packed {
      logic       ext_ack;
      logic [3:0] count;
   } csx_wait_t;

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Upper three bits give an even count, low bit adds one
   function automatic csx_wait_t csx_wait_decode(input logic [2:0] hi, input logic lo);
      csx_wait_t w;
      w.ext_ack = (hi == `CSX_WAIT_EXT_CODE);
      w.count = w.ext_ack ? 4'h0 : {hi, lo};
      return w;
   endfunction

   // Extra high bit only counts while enabled
   function automatic logic [2:0] csx_ups_join(input logic en, input logic hi,
                                               input logic [1:0] lo);
      return {en & hi, lo};
   endfunction

endpackage

`default_nettype wire

// File: csx_unprot.sv
`timescale 1ns/1ps
`default_nettype none
`include "csx_regs.svh"

module csx_unprot (
   input wire logic CLK_SYS,          // System clock
   input wire logic RST,              // Synchronous reset
   input wire logic [2:0] ups,        // Effective unprotected-size value
   input wire logic [31:0] space,     // Chip-select space in bytes
   output logic [2:0] ups_q,          // Registered size value
   output logic [31:0] bytes_q        // Registered unprotected bytes
);
   import csx_pkg::*;

   // ****************************************************************
   // Region is the space divided by two to the seven minus value
   // ****************************************************************
   wire [2:0] shift_amt = `CSX_UPS_TOP - ups;
   wire [31:0] bytes_d = space >> shift_amt;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ups_q <= 3'h0;
         bytes_q <= 32'h0000_0000;
      end else begin
         ups_q <= ups;
         bytes_q <= bytes_d; // see R14
      end
   end

endmodule // csx_unprot

`default_nettype wire

// File: csx_ctrl.sv
// What this block does
// R1: Extra-size enable joins group B, C, D high bits into three-bit sizes.
// R2: Wide SRAM select clear: group B pins act as write strobes.
// R3: Wide SRAM select set: group B pins act as byte selects.
// R4: Bit 12 is emulation wait-state low bit under three register bits.
// R5: Bit 11 is group D wait-state low bit.
// R6: Bit 10 is group C wait-state low bit.
// R7: Bit 9 is group B wait-state low bit.
// R8: Bit 8 is group A wait-state low bit.
// R9: DRAM extension gives 8 Mbyte for code 000, 16 Mbyte for 001.
// R10: DRAM extension acts only while group D DRAM selection is set.
// R11: Bit 4 is group D unprotected-size high bit when enabled.
// R12: Bit 2 is group C unprotected-size high bit when enabled.
// R13: Bit 0 is group B unprotected-size high bit when enabled.
// R14: Unprotected region is space divided by two to seven minus value.
// R15: Software writes zero to reserved bits 15, 7, 5, 3, 1.
// R16: Whole register clears to zero on reset.
// R17: Wait value: upper bits give even count plus low bit; 111 external.
// R18: Extension disabled: extra size bits ignored, two-bit fields used.
`timescale 1ns/1ps
`default_nettype none
`include "csx_regs.svh"

module csx_ctrl (
   input wire logic CLK_SYS,                    // System clock, 40 MHz
   input wire logic RST,                        // Synchronous reset
   input wire logic [11:0] REG_ADDR,            // Register address
   input wire logic [15:0] REG_WDATA,           // Register write data
   input wire logic REG_WR,                     // Write strobe
   input wire logic REG_RD,                     // Read strobe
   output logic [15:0] REG_RDATA,               // Read data, cycle after strobe
   input wire logic [2:0] A_WAIT_HI,            // Group A wait upper bits
   input wire logic [2:0] B_WAIT_HI,            // Group B wait upper bits
   input wire logic [2:0] C_WAIT_HI,            // Group C wait upper bits
   input wire logic [2:0] D_WAIT_HI,            // Group D wait upper bits
   input wire logic [2:0] EMU_WAIT_HI,          // Emulation wait upper bits
   input wire logic [1:0] B_UNPROT_LO,          // Group B two-bit size field
   input wire logic [1:0] C_UNPROT_LO,          // Group C two-bit size field
   input wire logic [1:0] D_UNPROT_LO,          // Group D two-bit size field
   input wire logic D_DRAM_SEL,                 // Group D selects DRAM
   input wire logic [2:0] D_SPACE_CODE,         // Group D space size code
   input wire logic [31:0] B_SPACE_BYTES,       // Group B space in bytes
   input wire logic [31:0] C_SPACE_BYTES,       // Group C space in bytes
   input wire logic [31:0] D_SPACE_BYTES,       // Group D base space in bytes
   input wire logic B_CYCLE,                    // Group B cycle active
   input wire logic B_WRITE,                    // Group B cycle is a write
   input wire logic B_UPPER_EN,                 // Upper byte lane used
   input wire logic B_LOWER_EN,                 // Lower byte lane used
   output var csx_pkg::csx_wait_t A_WAIT,       // Group A decoded wait
   output var csx_pkg::csx_wait_t B_WAIT,       // Group B decoded wait
   output var csx_pkg::csx_wait_t C_WAIT,       // Group C decoded wait
   output var csx_pkg::csx_wait_t D_WAIT,       // Group D decoded wait
   output var csx_pkg::csx_wait_t EMU_WAIT,     // Emulation decoded wait
   output logic [2:0] B_UNPROT_SIZE,            // Group B effective size value
   output logic [2:0] C_UNPROT_SIZE,            // Group C effective size value
   output logic [2:0] D_UNPROT_SIZE,            // Group D effective size value
   output logic [31:0] B_UNPROT_BYTES,          // Group B unprotected bytes
   output logic [31:0] C_UNPROT_BYTES,          // Group C unprotected bytes
   output logic [31:0] D_UNPROT_BYTES,          // Group D unprotected bytes
   output logic [31:0] D_SPACE_EFF,             // Group D effective space
   output logic UPPER_STROBE_N,                 // Upper write strobe or byte select
   output logic LOWER_STROBE_N,                 // Lower write strobe or byte select
   output logic STROBE_IS_BYTE_SEL              // Shared pins in byte-select role
);
   import csx_pkg::*;

   // ****************************************************************
   // Register decode
   // ****************************************************************
   csx_ctrl_t ctrl_q;
   csx_ctrl_t ctrl_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   wire hit_ctrl = (REG_ADDR == `CSX_CTRL_ADDR);
   wire hit_stat = (REG_ADDR == `CSX_STAT_ADDR);
   wire wr_ctrl = REG_WR & hit_ctrl;

   // Reserved positions are never stored, so they read back zero
   wire [15:0] wr_value = REG_WDATA & `CSX_CTRL_WMASK; // see R15
   assign ctrl_d = wr_ctrl ? csx_ctrl_t'(wr_value) : ctrl_q;

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         ctrl_q <= csx_ctrl_t'(`CSX_CTRL_RESET); // see R16
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // ****************************************************************
   // Wait-state values
   // ****************************************************************
   csx_wait_t a_wait_d;
   csx_wait_t b_wait_d;
   csx_wait_t c_wait_d;
   csx_wait_t d_wait_d;
   csx_wait_t emu_wait_d;

   assign a_wait_d = csx_wait_decode(A_WAIT_HI, ctrl_q.group_a_wait_low_bit); // see R8 R17
   assign b_wait_d = csx_wait_decode(B_WAIT_HI, ctrl_q.group_b_wait_low_bit); // see R7 R17
   assign c_wait_d = csx_wait_decode(C_WAIT_HI, ctrl_q.group_c_wait_low_bit); // see R6 R17
   assign d_wait_d = csx_wait_decode(D_WAIT_HI, ctrl_q.group_d_wait_low_bit); // see R5 R17
   assign emu_wait_d = csx_wait_decode(EMU_WAIT_HI, ctrl_q.emu_wait_low_bit); // see R4 R17

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         A_WAIT <= '0;
         B_WAIT <= '0;
         C_WAIT <= '0;
         D_WAIT <= '0;
         EMU_WAIT <= '0;
      end else begin
         A_WAIT <= a_wait_d;
         B_WAIT <= b_wait_d;
         C_WAIT <= c_wait_d;
         D_WAIT <= d_wait_d;
         EMU_WAIT <= emu_wait_d;
      end
   end

   // ****************************************************************
   // Unprotected-size fields
   // ****************************************************************
   wire eup_en = ctrl_q.extra_unprot_size_enable;
   // Disabled enable masks the high bit, leaving the two-bit field
   wire [2:0] b_ups = csx_ups_join(eup_en, ctrl_q.group_b_unprot_high_bit,
                                   B_UNPROT_LO); // see R1 R13 R18
   wire [2:0] c_ups = csx_ups_join(eup_en, ctrl_q.group_c_unprot_high_bit,
                                   C_UNPROT_LO); // see R1 R12 R18
   wire [2:0] d_ups = csx_ups_join(eup_en, ctrl_q.group_d_unprot_high_bit,
                                   D_UNPROT_LO); // see R1 R11 R18

   // ****************************************************************
   // Group D DRAM space
   // ****************************************************************
   wire dram_ext_on = ctrl_q.dram_space_extend & D_DRAM_SEL; // see R10
   wire code_8m = (D_SPACE_CODE == `CSX_DCODE_8M);
   wire code_16m = (D_SPACE_CODE == `CSX_DCODE_16M);
   logic [31:0] d_space_d;

   always_comb begin
      d_space_d = D_SPACE_BYTES;
      if (dram_ext_on && code_8m) begin
         d_space_d = `CSX_DRAM_8M; // see R9
      end else if (dram_ext_on && code_16m) begin
         d_space_d = `CSX_DRAM_16M; // see R9
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         D_SPACE_EFF <= 32'h0000_0000;
      end else begin
         D_SPACE_EFF <= d_space_d;
      end
   end

   // ****************************************************************
   // Unprotected region per group
   // ****************************************************************
   csx_unprot u_unprot_b (
      .CLK_SYS (CLK_SYS),
      .RST     (RST),
      .ups     (b_ups),
      .space   (B_SPACE_BYTES),
      .ups_q   (B_UNPROT_SIZE),
      .bytes_q (B_UNPROT_BYTES)
   ); // see R14

   csx_unprot u_unprot_c (
      .CLK_SYS (CLK_SYS),
      .RST     (RST),
      .ups     (c_ups),
      .space   (C_SPACE_BYTES),
      .ups_q   (C_UNPROT_SIZE),
      .bytes_q (C_UNPROT_BYTES)
   ); // see R14

   // Group D divides the space after the DRAM extension
   csx_unprot u_unprot_d (
      .CLK_SYS (CLK_SYS),
      .RST     (RST),
      .ups     (d_ups),
      .space   (d_space_d),
      .ups_q   (D_UNPROT_SIZE),
      .bytes_q (D_UNPROT_BYTES)
   ); // see R14

   // ****************************************************************
   // Group B shared strobe pins
   // ****************************************************************
   wire byte_sel_mode = ctrl_q.wide_sram_select;
   // Write strobes only on writes; byte selects on reads and writes
   wire b_lane_cycle = B_CYCLE & (byte_sel_mode | B_WRITE); // see R2 R3
   wire upper_d_n = ~(b_lane_cycle & B_UPPER_EN);
   wire lower_d_n = ~(b_lane_cycle & B_LOWER_EN);

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         UPPER_STROBE_N <= 1'b1;
         LOWER_STROBE_N <= 1'b1;
         STROBE_IS_BYTE_SEL <= 1'b0;
      end else begin
         UPPER_STROBE_N <= upper_d_n;
         LOWER_STROBE_N <= lower_d_n;
         STROBE_IS_BYTE_SEL <= byte_sel_mode; // see R2 R3
      end
   end

   // ****************************************************************
   // Read-back
   // ****************************************************************
   // Status shows live decode results of the block
   wire [15:0] stat_word = {1'b0, dram_ext_on,
                            emu_wait_d.ext_ack, d_wait_d.ext_ack, c_wait_d.ext_ack,
                            b_wait_d.ext_ack, a_wait_d.ext_ack,
                            d_ups, c_ups, b_ups};

   always_comb begin
      rdata_d = `CSX_RDATA_IDLE;
      if (REG_RD && hit_ctrl) begin
         rdata_d = ctrl_q;
      end else if (REG_RD && hit_stat) begin
         rdata_d = stat_word;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rdata_q <= `CSX_RDATA_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;

endmodule // csx_ctrl

`default_nettype wire

// File: csx_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "csx_regs.svh"
module csx_ctrl_chk (
   input wire logic CLK_SYS, // Clock
   input wire logic RST, // Reset
   input wire logic [11:0] REG_ADDR, // Address
   input wire logic [15:0] REG_WDATA, // Write data
   input wire logic REG_WR, // Write strobe
   input wire logic REG_RD, // Read strobe
   input wire logic [15:0] REG_RDATA, // Read data
   input wire logic [2:0] B_WAIT_HI, // Group B wait upper bits
   input wire csx_pkg::csx_wait_t B_WAIT, // Group B wait
   input wire logic B_CYCLE, // Group B cycle
   input wire logic B_WRITE, // Group B write
   input wire logic B_UPPER_EN, // Upper lane
   input wire logic UPPER_STROBE_N, // Upper pin
   input wire logic STROBE_IS_BYTE_SEL // Pin role
);
   import csx_pkg::*;
   // ********
   // Shadow of the control register
   // ********
   logic [15:0] ctrl_q;
   logic [15:0] ctrl_d;
   logic [1:0] up_q;
   logic [1:0] up_d;
   assign ctrl_d = (REG_WR && REG_ADDR == `CSX_CTRL_ADDR) ? (REG_WDATA & `CSX_CTRL_WMASK) : ctrl_q;
   assign up_d = (up_q == 2'h2) ? up_q : up_q + 2'h1;
   always_ff @(posedge CLK_SYS) begin
      ctrl_q <= RST ? `CSX_CTRL_RESET : ctrl_d;
      up_q <= RST ? 2'h0 : up_d;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   sequence s_ctrl_rd;
      REG_RD && REG_ADDR == `CSX_CTRL_ADDR;
   endsequence
   sequence s_void_rd;
      REG_RD && REG_ADDR != `CSX_CTRL_ADDR && REG_ADDR != `CSX_STAT_ADDR;
   endsequence
   a_ctrl_readback: assert property (s_ctrl_rd |=> REG_RDATA == $past(ctrl_q))
      else $error("control readback differs");
   a_unmapped_read: assert property (s_void_rd |=> REG_RDATA == 16'h0000)
      else $error("unmapped read not zero");
   a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
      else $error("read data outside read slot");
   a_byte_role: assert property (up_q == 2'h2 |-> STROBE_IS_BYTE_SEL == $past(ctrl_q[13]))
      else $error("pin role wrong");
   a_wait_ext: assert property (up_q == 2'h2 && $past(B_WAIT_HI) == 3'h7 |->
      B_WAIT.ext_ack && B_WAIT.count == 4'h0)
      else $error("external wait not flagged");
   a_wait_count: assert property (up_q == 2'h2 && $past(B_WAIT_HI) != 3'h7 |->
      !B_WAIT.ext_ack && B_WAIT.count == {$past(B_WAIT_HI), $past(ctrl_q[9])})
      else $error("group B wait count wrong");
   a_write_strobe: assert property (up_q == 2'h2 && !ctrl_q[13] && B_CYCLE && B_WRITE
      && B_UPPER_EN |=> !UPPER_STROBE_N)
      else $error("write strobe missing");
   a_read_quiet: assert property (up_q == 2'h2 && !ctrl_q[13] && B_CYCLE && !B_WRITE
      |=> UPPER_STROBE_N)
      else $error("write strobe on read");
   a_byte_select: assert property (up_q == 2'h2 && ctrl_q[13] && B_CYCLE && B_UPPER_EN
      |=> !UPPER_STROBE_N)
      else $error("byte select missing");
endmodule // csx_ctrl_chk
`default_nettype wire

// File: csx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module csx_mem_model (
   input wire logic CLK_SYS, // Clock
   input wire logic UPPER_N, // Upper pin
   input wire logic LOWER_N, // Lower pin
   input wire logic BYTE_SEL, // Pins act as byte selects
   output logic [1:0] LANES, // Lanes of last access
   output logic MODE // Role at last access
);
   // Memory latches which lanes an access touched
   always_ff @(posedge CLK_SYS) begin
      if (!UPPER_N || !LOWER_N) begin
         LANES <= {!UPPER_N, !LOWER_N};
         MODE <= BYTE_SEL;
      end
   end
endmodule // csx_mem_model
`default_nettype wire

// File: csx_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "csx_regs.svh"
module csx_ctrl_tb;
   import csx_pkg::*;
   typedef struct packed {
      logic [15:0] ctrl;
      logic [2:0] hi;
      logic [1:0] lo;
      logic ds;
      logic [2:0] dc, bs, cs, dz;
      logic [31:0] sp, bb, db;
   } csx_row_t;
   localparam int NR = 7;
   csx_row_t rows [NR] = '{
      '{16'h4015, 3'h1, 2'h3, 1'b0, 3'h0, 3'h7, 3'h7, 3'h7, 32'h200000, 32'h400000, 32'h200000},
      '{16'h0015, 3'h7, 2'h3, 1'b0, 3'h0, 3'h3, 3'h3, 3'h3, 32'h200000, 32'h40000, 32'h20000},
      '{16'h1F40, 3'h6, 2'h0, 1'b1, 3'h0, 3'h0, 3'h0, 3'h0, 32'h800000, 32'h8000, 32'h10000},
      '{16'h0040, 3'h0, 2'h1, 1'b1, 3'h1, 3'h1, 3'h1, 3'h1, 32'h1000000, 32'h10000, 32'h40000},
      '{16'h0040, 3'h2, 2'h2, 1'b0, 3'h1, 3'h2, 3'h2, 3'h2, 32'h200000, 32'h20000, 32'h10000},
      '{16'h4010, 3'h5, 2'h0, 1'b0, 3'h0, 3'h0, 3'h0, 3'h4, 32'h200000, 32'h8000, 32'h40000},
      '{16'h5F55, 3'h3, 2'h1, 1'b1, 3'h0, 3'h5, 3'h5, 3'h5, 32'h800000, 32'h100000, 32'h200000}};
   logic CLK_SYS = 1'b0;
   logic RST = 1'b1;
   logic REG_WR = 1'b0;
   logic REG_RD = 1'b0;
   logic [11:0] REG_ADDR = 12'h000;
   logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, rdv;
   logic [2:0] hi = 3'h0, dcode = 3'h0, bsz, csz, dsz;
   logic [1:0] lo = 2'h0, lanes;
   logic dsel = 1'b0, bcyc = 1'b0, bwr = 1'b0, bue = 1'b0, ble = 1'b0;
   logic mode, un, ln, bsel;
   csx_wait_t aw, bw, cw, dw, ew;
   logic [31:0] bb, cb, db, dsp;
   int n_mismatch = 0;
   int comparisons = 0;
   always #12.5 CLK_SYS = ~CLK_SYS;
   csx_ctrl u_csx_ctrl (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .A_WAIT_HI(hi), .B_WAIT_HI(hi),
      .C_WAIT_HI(hi), .D_WAIT_HI(hi), .EMU_WAIT_HI(hi), .B_UNPROT_LO(lo), .C_UNPROT_LO(lo),
      .D_UNPROT_LO(lo), .D_DRAM_SEL(dsel), .D_SPACE_CODE(dcode), .B_SPACE_BYTES(32'h0040_0000),
      .C_SPACE_BYTES(32'h0040_0000), .D_SPACE_BYTES(32'h0020_0000), .B_CYCLE(bcyc),
      .B_WRITE(bwr), .B_UPPER_EN(bue), .B_LOWER_EN(ble), .A_WAIT(aw), .B_WAIT(bw), .C_WAIT(cw),
      .D_WAIT(dw), .EMU_WAIT(ew), .B_UNPROT_SIZE(bsz), .C_UNPROT_SIZE(csz), .D_UNPROT_SIZE(dsz),
      .B_UNPROT_BYTES(bb), .C_UNPROT_BYTES(cb), .D_UNPROT_BYTES(db), .D_SPACE_EFF(dsp),
      .UPPER_STROBE_N(un), .LOWER_STROBE_N(ln), .STROBE_IS_BYTE_SEL(bsel));
   csx_mem_model u_csx_mem_model (.CLK_SYS(CLK_SYS), .UPPER_N(un), .LOWER_N(ln),
      .BYTE_SEL(bsel), .LANES(lanes), .MODE(mode));
   // ********
   // Bus tasks and comparison
   // ********
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
      @(posedge CLK_SYS);
   endtask
   task automatic rd(input logic [11:0] a);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      @(negedge CLK_SYS);
      rdv = REG_RDATA;
      @(posedge CLK_SYS);
   endtask
   function automatic csx_wait_t wx(input logic [2:0] h, input logic l);
      return (h == 3'h7) ? 5'h10 : {1'b0, h, l};
   endfunction
   task automatic complete_run;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge CLK_SYS);
      n_mismatch++;
      complete_run;
   end
   // ********
   // Scenarios
   // ********
   initial begin
      repeat (16) @(posedge CLK_SYS);
      RST <= 1'b0;
      rd(`CSX_CTRL_ADDR);
      chk("reset value", rdv, 16'h0000);
      for (int i = 0; i < NR; i++) begin
         hi <= rows[i].hi;
         lo <= rows[i].lo;
         dsel <= rows[i].ds;
         dcode <= rows[i].dc;
         wr(`CSX_CTRL_ADDR, rows[i].ctrl);
         @(posedge CLK_SYS);
         @(negedge CLK_SYS);
         chk("A wait", aw, wx(hi, rows[i].ctrl[8]));
         chk("B wait", bw, wx(hi, rows[i].ctrl[9]));
         chk("C wait", cw, wx(hi, rows[i].ctrl[10]));
         chk("D wait", dw, wx(hi, rows[i].ctrl[11]));
         chk("EMU wait", ew, wx(hi, rows[i].ctrl[12]));
         chk("B size", bsz, rows[i].bs);
         chk("C size", csz, rows[i].cs);
         chk("D size", dsz, rows[i].dz);
         chk("D space", dsp, rows[i].sp);
         chk("B bytes", bb, rows[i].bb);
         chk("C bytes", cb, rows[i].bb);
         chk("D bytes", db, rows[i].db);
         @(posedge CLK_SYS);
      end
      rd(`CSX_STAT_ADDR);
      chk("status word", rdv, 16'h416D);
      wr(`CSX_CTRL_ADDR, 16'h4004);
      @(negedge CLK_SYS);
      chk("B size alone", bsz, 3'h1);
      chk("C size alone", csz, 3'h5);
      @(posedge CLK_SYS);
      wr(`CSX_CTRL_ADDR, 16'hFFFF);
      rd(`CSX_CTRL_ADDR);
      chk("reserved bits", rdv, 16'h7F55);
      wr(12'h100, 16'h0000);
      rd(`CSX_CTRL_ADDR);
      chk("unmapped write", rdv, 16'h7F55);
      rd(12'h100);
      chk("unmapped read", rdv, 16'h0000);
      for (int m = 0; m < 2; m++) begin
         wr(`CSX_CTRL_ADDR, m ? 16'h2000 : 16'h0000);
         for (int k = 0; k < 8; k++) begin
            bcyc <= 1'b1;
            bwr <= k[2];
            bue <= k[1];
            ble <= k[0];
            @(posedge CLK_SYS);
            @(negedge CLK_SYS);
            chk("upper pin", un, !(k[1] && (m || k[2])));
            chk("lower pin", ln, !(k[0] && (m || k[2])));
            chk("pin role", bsel, m);
            @(posedge CLK_SYS);
         end
         bcyc <= 1'b0;
         repeat (2) @(posedge CLK_SYS);
         @(negedge CLK_SYS);
         chk("idle pin", un, 1'b1);
         chk("idle pin low", ln, 1'b1);
         chk("model lanes", lanes, 2'h3);
         chk("model role", mode, m);
         @(posedge CLK_SYS);
      end
      wr(`CSX_CTRL_ADDR, 16'h4015);
      RST <= 1'b1;
      @(posedge CLK_SYS);
      RST <= 1'b0;
      rd(`CSX_CTRL_ADDR);
      chk("second reset", rdv, 16'h0000);
      complete_run;
   end
endmodule // csx_ctrl_tb
bind csx_ctrl csx_ctrl_chk u_csx_ctrl_chk (.CLK_SYS(CLK_SYS), .RST(RST), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .B_WAIT_HI(B_WAIT_HI), .B_WAIT(B_WAIT), .B_CYCLE(B_CYCLE), .B_WRITE(B_WRITE),
   .B_UPPER_EN(B_UPPER_EN), .UPPER_STROBE_N(UPPER_STROBE_N),
   .STROBE_IS_BYTE_SEL(STROBE_IS_BYTE_SEL));
`default_nettype wire
